// ===== verilog/video_sync_pkg.sv
package video_sync_pkg;

    // Register geometry
    localparam int DATA_W   = 12;
    localparam int BYTE_W   = 8;
    localparam int HIGH_W   = 4;
    localparam int NUM_REGS = 19;
    localparam int CNT_W    = 13;

    // Register offsets
    localparam logic [7:0] MODE_OUTPUT_CONTROL    = 8'h00;
    localparam logic [7:0] H_FRONT_PORCH          = 8'h01;
    localparam logic [7:0] H_SYNC_END             = 8'h02;
    localparam logic [7:0] H_BLANK_WIDTH          = 8'h03;
    localparam logic [7:0] H_TOTAL_CLOCKS         = 8'h04;
    localparam logic [7:0] V_FRONT_PORCH          = 8'h05;
    localparam logic [7:0] V_SYNC_END             = 8'h06;
    localparam logic [7:0] V_BLANK_WIDTH          = 8'h07;
    localparam logic [7:0] V_TOTAL_LINES          = 8'h08;
    localparam logic [7:0] EQUALIZE_PULSE_END     = 8'h09;
    localparam logic [7:0] SERRATE_PULSE_END      = 8'h0a;
    localparam logic [7:0] EQ_SERR_INTERVAL_START = 8'h0b;
    localparam logic [7:0] EQ_SERR_INTERVAL_END   = 8'h0c;
    localparam logic [7:0] V_IRQ_ACTIVATE         = 8'h0d;
    localparam logic [7:0] V_IRQ_DEACTIVATE       = 8'h0e;
    localparam logic [7:0] H_POINTER_START        = 8'h0f;
    localparam logic [7:0] H_POINTER_END          = 8'h10;
    localparam logic [7:0] V_POINTER_START        = 8'h11;
    localparam logic [7:0] V_POINTER_END          = 8'h12;

    // Status field positions
    localparam int ST_SEP_BLANK = 0;
    localparam int ST_SEP_SYNC  = 1;
    localparam int ST_HELPER    = 2;
    localparam int ST_MODE_LO   = 3;
    localparam int ST_POL_VCB   = 5;
    localparam int ST_POL_VCS   = 6;
    localparam int ST_POL_HBD   = 7;
    localparam int ST_POL_HSV   = 8;
    localparam int ST_EQ_OFF    = 9;
    localparam int ST_CLK_EN    = 10;

    // Reset values
    localparam logic [11:0] STATUS_RESET_BASE = 12'h000;
    localparam logic [11:0] STATUS_RESET_AUTO = 12'h400;
    localparam logic [11:0] DATA_RESET        = 12'h000;
    localparam logic [11:0] HCOUNT_RESET      = 12'hfff;
    localparam logic [12:0] VUNIT_RESET       = 13'h1fff;

    typedef enum logic [1:0] {
        MODE_IL_DOUBLE = 2'b00,
        MODE_NI_DOUBLE = 2'b01,
        MODE_ILLEGAL   = 2'b10,
        MODE_NI_SINGLE = 2'b11
    } mode_t;

    typedef struct packed {
        logic       load;
        logic       addrData;
        logic       byteHalf;
        logic [7:0] data;
    } pins_t;

    typedef struct packed {
        logic vert_or_comp_sync_out;
        logic vert_or_comp_blank_out;
        logic hbDrive;
        logic hsVdrive;
        logic parity;
    } outs_t;

endpackage

// ===== verilog/video_sync_gen.sv
`timescale 1ns/100ps
// Behaviour
// - Load fall latches address-or-data select
// - Byte half picks low 8 or high 4
// - Half high with address select enables auto-load
// - Load rise writes address or data half
// - Load asynchronous; outputs change on pixel fall
// - Clear asynchronously restores defaults and counters
// - Clear leaves clock off, auto-start on
// - Parity high odd, low even, high non-interlaced
// - Eq/serration only on composite sync output
// - Twelve-bit registers; pulses by start/end counts
// - Status resets 000 or 400 hex
// - Status bits 0-2 choose output signals
// - Status bits 4:3 choose scan mode
// - Double mode two eq/serration pulses per line
// - Bits 5-8 set output polarities
// - Bit 9 low enables eq/serration
// - Bit 10 gates timing generation
// - Registers 1-4 horizontal timing
// - Registers 5-8 vertical timing
// - Registers 9-12 eq/serration timing
// - Registers 13-18 interrupt, cursor, gating
// - Auto-load: low then high, high increments
// - Address counter wraps to start at 18
// - Horizontal count runs one to line total
// - Composite is OR of active-high parts
module video_sync_gen #(
    parameter bit AUTO_START = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       asyncInitInput,
    input  wire logic       pixelClock,
    input  wire logic       loadStrobe,
    input  wire logic       addrDataSelect,
    input  wire logic       byteHalfSelect,
    input  wire logic [7:0] bytePortInputs,
    output logic            vertOrCompSyncOut,
    output logic            vertOrCompBlankOut,
    output logic            horizBlankOrDriveOut,
    output logic            horizSyncOrVdriveOut,
    output logic            fieldParityOut
);

    localparam logic [7:0] LAST_REG = video_sync_pkg::V_POINTER_END;

    typedef struct packed {
        video_sync_pkg::pins_t             pinS1;
        video_sync_pkg::pins_t             pinS2;
        logic                              loadPrev;
        logic                              pixS1;
        logic                              pixS2;
        logic                              pixS3;
        logic                              latchSel;
        logic                              latchHalf;
        logic                              autoMode;
        logic [7:0]                        addr;
        logic [7:0]                        startAddr;
        logic [18:0][11:0]                 regs;
        logic [11:0]                       hCount;
        logic [12:0]                       vUnit;
        video_sync_pkg::outs_t             outs;
    } state_t;

    state_t                     st;
    state_t                     next_st;
    video_sync_pkg::pins_t      pinsIn;
    video_sync_pkg::mode_t      mode;
    logic                       loadFall;
    logic                       loadRise;
    logic                       pixFall;
    logic                       clkEn;
    logic [4:0]                 wrIdx;
    logic [7:0]                 nextAddr;

    // Register bank below is sized for exactly nineteen words
    if (video_sync_pkg::NUM_REGS != 19) begin : g_chk
        $error("Register count must be 19");
    end

    // Inclusive start, exclusive end window
    function automatic logic inRange(
        input logic [12:0] pos,
        input logic [11:0] first,
        input logic [11:0] last
    );
        inRange = (pos >= {1'b0, first}) && (pos < {1'b0, last});
    endfunction

    // Active-high internal level turned to programmed polarity
    function automatic logic polar(input logic x, input logic pol);
        polar = pol ? x : ~x;
    endfunction

    assign pinsIn   = '{load: loadStrobe, addrData: addrDataSelect,
                        byteHalf: byteHalfSelect, data: bytePortInputs};
    assign loadFall = st.loadPrev & ~st.pinS2.load;
    assign loadRise = ~st.loadPrev & st.pinS2.load;
    assign pixFall  = st.pixS3 & ~st.pixS2;
    assign clkEn    = st.regs[0][video_sync_pkg::ST_CLK_EN];
    assign mode     = video_sync_pkg::mode_t'(st.regs[0][video_sync_pkg::ST_MODE_LO +: 2]);
    assign wrIdx    = st.addr[4:0];
    // Loops on the start address; a start at or past the end repeats
    assign nextAddr = (st.addr >= LAST_REG) ? st.startAddr : st.addr + 8'h01;

    // Next state: synchronisers, byte port, timing counters, outputs
    always_comb begin
        logic        il;
        logic        dbl;
        logic [11:0] clocks_per_line_limit;
        logic [11:0] hMid;
        logic [12:0] vMax;
        logic [11:0] hc;
        logic [12:0] vu;
        logic [12:0] vLine;
        logic [12:0] pos;
        logic        hb;
        logic        vb;
        logic        hs;
        logic        vs;
        logic        cs;
        logic        cb;
        logic        hg;
        logic        vg;
        logic        vertical_interrupt;
        logic        inIntv;
        logic        sepB;
        logic        sepS;
        logic        helper;
        logic        halfTick;
        il       = 1'b0;
        dbl      = 1'b0;
        clocks_per_line_limit     = '0;
        hMid     = '0;
        vMax     = '0;
        hc       = '0;
        vu       = '0;
        vLine    = '0;
        pos      = '0;
        hb       = 1'b0;
        vb       = 1'b0;
        hs       = 1'b0;
        vs       = 1'b0;
        cs       = 1'b0;
        cb       = 1'b0;
        hg       = 1'b0;
        vg       = 1'b0;
        vertical_interrupt     = 1'b0;
        inIntv   = 1'b0;
        sepB     = 1'b0;
        sepS     = 1'b0;
        helper   = 1'b0;
        halfTick = 1'b0;
        next_st  = st;

        // Pins pass two flops before anything reads them
        next_st.pinS1    = pinsIn;
        next_st.pinS2    = st.pinS1;
        next_st.loadPrev = st.pinS2.load;
        next_st.pixS1    = pixelClock;
        next_st.pixS2    = st.pixS1;
        next_st.pixS3    = st.pixS2;

        // Select and half are caught on the falling strobe
        if (loadFall) begin
            next_st.latchSel  = st.pinS2.addrData;
            next_st.latchHalf = st.pinS2.byteHalf;
            if (!st.pinS2.addrData) begin
                next_st.autoMode = st.pinS2.byteHalf;
            end
        end

        // Byte port writes on the rising strobe, whatever clkEn says
        if (loadRise) begin
            if (!st.latchSel) begin
                next_st.addr      = st.pinS2.data;
                next_st.startAddr = st.pinS2.data;
            end else if (st.addr <= LAST_REG) begin
                if (!st.latchHalf) begin
                    next_st.regs[wrIdx][7:0] = st.pinS2.data;
                end else begin
                    next_st.regs[wrIdx][11:8] = st.pinS2.data[3:0];
                    if (st.autoMode) begin
                        next_st.addr = nextAddr;
                    end
                end
            end
        end

        // Timing advances only on a pixel falling edge with the clock on
        if (pixFall && clkEn) begin
            il   = (mode == video_sync_pkg::MODE_IL_DOUBLE);
            dbl  = (mode != video_sync_pkg::MODE_NI_SINGLE);
            clocks_per_line_limit = st.regs[4];
            hMid = clocks_per_line_limit >> 1;
            vMax = il ? {st.regs[8], 1'b0} : {1'b0, st.regs[8]};
            hc   = (st.hCount >= clocks_per_line_limit) ? 12'h001 : st.hCount + 12'h001;
            halfTick = (st.hCount >= clocks_per_line_limit) || (il && st.hCount == hMid);
            vu   = st.vUnit;
            if (halfTick) begin
                vu = (st.vUnit >= vMax) ? 13'h0001 : st.vUnit + 13'h0001;
            end
            next_st.hCount = hc;
            next_st.vUnit  = vu;
            // Interlaced vertical units are half-lines; gating uses lines
            vLine = il ? ((vu + 13'h0001) >> 1) : vu;
            pos   = (dbl && hc > hMid) ? {1'b0, hc - hMid} : {1'b0, hc};

            hb = {1'b0, hc} < {1'b0, st.regs[3]};
            hs = inRange({1'b0, hc}, st.regs[1], st.regs[2]);
            vb = vu < {1'b0, st.regs[7]};
            vs = inRange(vu, st.regs[5], st.regs[6]);
            hg = inRange({1'b0, hc}, st.regs[15], st.regs[16]);
            vg = inRange(vLine, st.regs[17], st.regs[18]);
            vertical_interrupt = inRange(vLine, st.regs[13], st.regs[14]);
            inIntv = inRange(vu, st.regs[11], st.regs[12])
                     && !st.regs[0][video_sync_pkg::ST_EQ_OFF];

            // Serration replaces vertical sync, equalization elsewhere
            if (inIntv) begin
                cs = vs ? !inRange(pos, st.regs[1], st.regs[10])
                        : inRange(pos, st.regs[1], st.regs[9]);
            end else begin
                cs = hs | vs;
            end
            cb = hb | vb;

            sepB   = st.regs[0][video_sync_pkg::ST_SEP_BLANK];
            sepS   = st.regs[0][video_sync_pkg::ST_SEP_SYNC];
            helper = st.regs[0][video_sync_pkg::ST_HELPER];
            // Output routing and polarity
            next_st.outs.vert_or_comp_blank_out = polar(sepB ? vb : cb,
                                         st.regs[0][video_sync_pkg::ST_POL_VCB]);
            next_st.outs.vert_or_comp_sync_out = polar(sepS ? vs : cs,
                                        st.regs[0][video_sync_pkg::ST_POL_VCS]);
            next_st.outs.hbDrive = polar(sepB ? hb : (helper ? (hg & vg) : hg),
                                         st.regs[0][video_sync_pkg::ST_POL_HBD]);
            next_st.outs.hsVdrive = polar(sepS ? hs : (helper ? vertical_interrupt : vg),
                                          st.regs[0][video_sync_pkg::ST_POL_HSV]);
            next_st.outs.parity = il ? (vu <= {1'b0, st.regs[8]}) : 1'b1;
        end
    end

    // One register bank; clear or reset forces the mask defaults
    always_ff @(posedge clk or negedge rstn or posedge asyncInitInput) begin
        if (!rstn || asyncInitInput) begin
            st <= '0;
            st.regs[0] <= AUTO_START ? video_sync_pkg::STATUS_RESET_AUTO
                                     : video_sync_pkg::STATUS_RESET_BASE;
            for (int i = 1; i < video_sync_pkg::NUM_REGS; i++) begin
                st.regs[i] <= video_sync_pkg::DATA_RESET;
            end
            st.hCount <= video_sync_pkg::HCOUNT_RESET;
            st.vUnit <= video_sync_pkg::VUNIT_RESET;
            st.outs.parity <= 1'b1;
            st.pinS1.load <= 1'b1; // Strobe idles high: no false rise after release
            st.pinS2.load <= 1'b1;
            st.loadPrev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign vertOrCompSyncOut    = st.outs.vert_or_comp_sync_out;
    assign vertOrCompBlankOut   = st.outs.vert_or_comp_blank_out;
    assign horizBlankOrDriveOut = st.outs.hbDrive;
    assign horizSyncOrVdriveOut = st.outs.hsVdrive;
    assign fieldParityOut       = st.outs.parity;

    // Checks on the byte port and timing core
    default clocking cb_clk @(posedge clk); endclocking
    default disable iff (!rstn || asyncInitInput);

    property p_addr_load;
        loadRise && !st.latchSel |=> st.addr == $past(st.pinS2.data);
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not loaded");

    property p_low_byte;
        loadRise && st.latchSel && !st.latchHalf && st.addr <= LAST_REG
        |=> st.regs[$past(wrIdx)][7:0] == $past(st.pinS2.data);
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte not written");

    property p_high_byte;
        loadRise && st.latchSel && st.latchHalf && st.addr <= LAST_REG
        |=> st.regs[$past(wrIdx)][11:8] == $past(st.pinS2.data[3:0]);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high nibble not written");

    property p_auto_on;
        loadFall && !st.pinS2.addrData |=> st.autoMode == $past(st.pinS2.byteHalf);
    endproperty
    a_auto_on: assert property (p_auto_on) else $error("auto mode not latched");

    property p_auto_inc;
        loadRise && st.latchSel && st.latchHalf && st.autoMode && st.addr < LAST_REG
        |=> st.addr == $past(st.addr) + 8'h01;
    endproperty
    a_auto_inc: assert property (p_auto_inc) else $error("address not incremented");

    property p_auto_wrap;
        loadRise && st.latchSel && st.latchHalf && st.autoMode && st.addr == LAST_REG
        |=> st.addr == $past(st.startAddr);
    endproperty
    a_auto_wrap: assert property (p_auto_wrap) else $error("address did not wrap");

    property p_hold;
        !clkEn |=> $stable(st.hCount) && $stable(st.vUnit) && $stable(st.outs);
    endproperty
    a_hold: assert property (p_hold) else $error("timing moved while disabled");

    property p_out_edge;
        !pixFall |=> $stable(st.outs);
    endproperty
    a_out_edge: assert property (p_out_edge) else $error("output changed off edge");

    property p_parity_ni;
        pixFall && clkEn && mode != video_sync_pkg::MODE_IL_DOUBLE |=> fieldParityOut;
    endproperty
    a_parity_ni: assert property (p_parity_ni) else $error("parity low in progressive");

    property p_line_wrap;
        pixFall && clkEn && st.hCount >= st.regs[4] |=> st.hCount == 12'h001;
    endproperty
    a_line_wrap: assert property (p_line_wrap) else $error("line count not restarted");

    property p_sel_latch;
        loadFall |=> st.latchSel == $past(st.pinS2.addrData);
    endproperty
    a_sel_latch: assert property (p_sel_latch) else $error("select not latched");

    property p_half_latch;
        loadFall |=> st.latchHalf == $past(st.pinS2.byteHalf);
    endproperty
    a_half_latch: assert property (p_half_latch) else $error("byte half not latched");

    property p_low_keeps;
        loadRise && st.latchSel && !st.latchHalf && st.addr <= LAST_REG
        |=> st.regs[$past(wrIdx)][11:8] == $past(st.regs[wrIdx][11:8]);
    endproperty
    a_low_keeps: assert property (p_low_keeps) else $error("high nibble disturbed");

    property p_lone_low;
        loadRise && st.latchSel && !st.latchHalf |=> $stable(st.addr);
    endproperty
    a_lone_low: assert property (p_lone_low) else $error("address moved on low byte");

    property p_far_write;
        loadRise && st.latchSel && st.addr > LAST_REG |=> $stable(st.regs);
    endproperty
    a_far_write: assert property (p_far_write) else $error("stray register write");

    property p_far_hold;
        loadRise && st.latchSel && st.latchHalf && st.addr > LAST_REG |=> $stable(st.addr);
    endproperty
    a_far_hold: assert property (p_far_hold) else $error("high start address moved");

    property p_hstep;
        pixFall && clkEn && st.hCount < st.regs[4] |=> st.hCount == $past(st.hCount) + 12'h001;
    endproperty
    a_hstep: assert property (p_hstep) else $error("line count skipped");

    sequence p_auto_inc_seq;
        loadRise && st.autoMode && st.latchHalf ##1 st.addr != $past(st.addr);
    endsequence
    c_auto_inc: cover property (p_auto_inc_seq);
    c_line_wrap: cover property (pixFall && clkEn ##1 st.hCount == 12'h001);
    c_interval: cover property (pixFall && st.vUnit == {1'b0, st.regs[11]});
    c_odd_even: cover property ($fell(fieldParityOut));

endmodule

// ===== verif/host_port_model.sv
`timescale 1ns/100ps
// Host side of the byte port: every pin moves just after a falling clk edge
// and is held long enough for the two-flop synchronisers to see it
module host_port_model (
    input  wire logic             clk,
    output video_sync_pkg::pins_t pins
);
    // Idle bus: strobe high, selects on data, bus parked
    initial begin
        pins = '{load: 1'b1, addrData: 1'b1, byteHalf: 1'b0, data: 8'h00};
    end

    // One strobe cycle; selects settle before the fall, the byte stays past the rise
    task automatic put(input logic sel, input logic half, input logic [7:0] d);
        @(negedge clk);
        pins.addrData = sel;
        pins.byteHalf = half;
        pins.data = d;
        repeat (3) @(negedge clk);
        pins.load = 1'b0;
        repeat (4) @(negedge clk);
        pins.load = 1'b1;
        repeat (4) @(negedge clk);
        pins.data = ~d; // A released bus must not keep showing the old byte
        repeat (2) @(negedge clk);
    endtask

    // Manual access: address, then low byte, then high nibble
    task automatic write_reg(input logic [7:0] addr, input logic [11:0] value);
        put(1'b0, 1'b0, addr);
        put(1'b1, 1'b0, value[7:0]);
        put(1'b1, 1'b1, {4'h0, value[11:8]});
    endtask

    // Address with the half select high turns on auto-load
    task automatic auto_start(input logic [7:0] addr);
        put(1'b0, 1'b1, addr);
    endtask

    // Low byte first, high byte second; the high byte advances the address
    task automatic auto_pair(input logic [11:0] value);
        put(1'b1, 1'b0, value[7:0]);
        put(1'b1, 1'b1, {4'h0, value[11:8]});
    endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/100ps
`define CHECK(name, exp, got) \
    begin \
        nCompared++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("unexpected %s expected %0d seen %0d", name, exp, got); \
        end \
    end

module tb_top;
    typedef struct {
        logic [11:0] status;
        int          exp [5];
    } row_t;

    localparam int LIMIT = 40000;

    logic                  clk;
    logic                  rstn;
    logic                  asyncInitInput;
    logic                  pixelClock;
    video_sync_pkg::pins_t pins;
    video_sync_pkg::outs_t outs;
    logic                  autoHbDrive;
    int                    cnt [6];
    int                    miscompares;
    int                    nCompared;
    int                    cycles = 0;

    // Line of 20 pixels, frame of 10 lines; front porch first loaded wrong on purpose
    logic [11:0] timing [1:18] = '{12'h007, 12'h006, 12'h009, 12'h014, 12'h002, 12'h004,
                                  12'h005, 12'h00a, 12'h004, 12'h008, 12'h001, 12'h004,
                                  12'h001, 12'h003, 12'h002, 12'h005, 12'h003, 12'h006};

    // High counts per 200-pixel frame: vert_or_comp_sync_out, vert_or_comp_blank_out, hbDrive, hsVdrive, parity.
    // -1 would leave an output unchecked; no row selects the illegal mode.
    // Last two rows put equalization and serration on composite sync, single then double
    row_t rows [8] = '{
        '{12'h7fb, '{40, 80, 80, 30, 200}},
        '{12'h61b, '{160, 120, 120, 170, 200}},
        '{12'h7f8, '{64, 128, 30, 60, 200}},
        '{12'h7fc, '{64, 128, 9, 40, 200}},
        '{12'h7e3, '{20, 40, 80, 30, 100}},
        '{12'h5fb, '{40, 80, 80, 30, 200}},
        '{12'h5f8, '{52, 128, 30, 60, 200}},
        '{12'h5e8, '{43, 128, 30, 60, 200}}};

    video_sync_gen #(.AUTO_START(1'b0)) dut (
        .clk                  (clk),
        .rstn                 (rstn),
        .asyncInitInput       (asyncInitInput),
        .pixelClock           (pixelClock),
        .loadStrobe           (pins.load),
        .addrDataSelect       (pins.addrData),
        .byteHalfSelect       (pins.byteHalf),
        .bytePortInputs       (pins.data),
        .vertOrCompSyncOut    (outs.vert_or_comp_sync_out),
        .vertOrCompBlankOut   (outs.vert_or_comp_blank_out),
        .horizBlankOrDriveOut (outs.hbDrive),
        .horizSyncOrVdriveOut (outs.hsVdrive),
        .fieldParityOut       (outs.parity)
    );

    // Auto-start variant shares the port, watched on its horizontal output only
    video_sync_gen #(.AUTO_START(1'b1)) dutAuto (
        .clk                  (clk),
        .rstn                 (rstn),
        .asyncInitInput       (asyncInitInput),
        .pixelClock           (pixelClock),
        .loadStrobe           (pins.load),
        .addrDataSelect       (pins.addrData),
        .byteHalfSelect       (pins.byteHalf),
        .bytePortInputs       (pins.data),
        .vertOrCompSyncOut    (),
        .vertOrCompBlankOut   (),
        .horizBlankOrDriveOut (autoHbDrive),
        .horizSyncOrVdriveOut (),
        .fieldParityOut       ()
    );

    host_port_model host (
        .clk  (clk),
        .pins (pins)
    );

    // System clock 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Pixel clock runs free at 320 ns, phase unrelated to clk
    initial begin
        pixelClock = 1'b0;
        #7;
        forever #160 pixelClock = ~pixelClock;
    end

    task automatic end_of_test;
        if (miscompares == 0 && nCompared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Any n consecutive pixel periods; sampled at the pin fall, before outputs move
    task automatic measure(input int n);
        cnt = '{default: 0};
        repeat (2) @(negedge pixelClock);
        repeat (n) begin
            @(negedge pixelClock);
            cnt[0] += int'(outs.vert_or_comp_sync_out === 1'b1);
            cnt[1] += int'(outs.vert_or_comp_blank_out === 1'b1);
            cnt[2] += int'(outs.hbDrive === 1'b1);
            cnt[3] += int'(outs.hsVdrive === 1'b1);
            cnt[4] += int'(outs.parity === 1'b1);
            cnt[5] += int'(autoHbDrive === 1'b1);
            `CHECK("known outputs", 1'b0, $isunknown({outs, autoHbDrive}))
        end
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        miscompares = 0;
        nCompared = 0;
        rstn = 1'b0;
        asyncInitInput = 1'b1;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        asyncInitInput = 1'b0;
        // Auto-load 1..18, then one extra pair must wrap onto the front porch
        host.auto_start(8'h01);
        for (int r = 1; r <= 18; r++) begin
            host.auto_pair(timing[r]);
        end
        host.auto_pair(12'h003);
        measure(200);
        `CHECK("base hbDrive idle", 0, cnt[2])
        `CHECK("base parity idle", 200, cnt[4])
        `CHECK("auto horizontal_gate count", 170, cnt[5])
        // Ordinary cases
        foreach (rows[i]) begin
            host.write_reg(8'h00, rows[i].status);
            measure(200);
            for (int k = 0; k < 5; k++) begin
                if (rows[i].exp[k] >= 0)
                    `CHECK("output count", rows[i].exp[k], cnt[k])
            end
        end
        // Clock gated off: nothing moves, yet a register write still lands
        host.write_reg(8'h00, 12'h3fb);
        measure(200);
        for (int k = 0; k < 5; k++) begin
            `CHECK("frozen output", 1'b1, (cnt[k] == 0 || cnt[k] == 200))
        end
        host.write_reg(8'h03, 12'h105);
        host.write_reg(8'h00, 12'h7fb);
        measure(200);
        `CHECK("wide blank count", 200, cnt[2])
        // Clear in mid-run restores defaults, base variant stays stopped
        @(negedge clk);
        asyncInitInput = 1'b1;
        repeat (3) @(negedge clk);
        `CHECK("outputs in clear", 5'b00001, outs)
        asyncInitInput = 1'b0;
        measure(50);
        `CHECK("hbDrive after clear", 0, cnt[2])
        `CHECK("parity after clear", 50, cnt[4])
        `CHECK("auto hbDrive after clear", 50, cnt[5])
        end_of_test();
    end
endmodule
